// ---- inc/scrc_pkg.sv ----
// Constants for the status, link-control and configuration register block.
// Assumes a single 25 MHz clock and an SPI port sampled synchronously.
`default_nettype none

package scrc_pkg;
    localparam logic [4:0] STATUS_ADDR = 5'h0C;
    localparam logic [4:0] CONFIG_ADDR = 5'h0D;
    localparam logic [9:0] STATUS_CTL_RESET = 10'h2A4;
    localparam logic [23:0] CONFIG_RESET = 24'h38_6050;
    localparam logic [23:0] CONFIG_MASK = 24'hFF_E0FF;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hA5;
    localparam logic [15:0] CHECKSUM_POLY = 16'h8005;
    // Field positions inside status_ctl_reg (status bits 23..14)
    localparam int CTL_IDLE_DRIVE = 6;
    localparam int CTL_WIDE_CHECKSUM = 4;
    localparam int CTL_COMM_CHECKSUM = 1;
    localparam int CTL_INT_ENABLE = 0;
    localparam logic [4:0] CMD_LAST = 5'd7;
    localparam logic [4:0] DATA_LAST = 5'd23;
    localparam logic [4:0] CHECK_SHORT_LAST = 5'd15;
    localparam logic [4:0] CHECK_LONG_LAST = 5'd31;

    typedef enum logic [1:0] {
        SCRC_IDLE = 2'b00,
        SCRC_DATA = 2'b01,
        SCRC_CHECK = 2'b10,
        SCRC_DONE = 2'b11
    } scrc_state_type;
endpackage : scrc_pkg

`default_nettype wire

// ---- hdl/scrc_checksum.sv ----
// Serial CRC-16 over the bits seen on the link.
// Assumes one bit per shift strobe, most significant bit first.
`default_nettype none

module scrc_checksum (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic clear,
    input wire logic shift,
    input wire logic bit_in,
    // Result
    output logic [15:0] crc_next,
    output logic [15:0] crc_value
);
    logic [15:0] crc_reg;

    always_comb begin
        crc_next = crc_reg;
        if (clear) begin
            crc_next = 16'h0000;
        end else if (shift) begin
            crc_next = {crc_reg[14:0], 1'b0} ^
                ((bit_in ^ crc_reg[15]) ? scrc_pkg::CHECKSUM_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crc_reg <= 16'h0000;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc_value = crc_reg;
endmodule : scrc_checksum

`default_nettype wire

// ---- hdl/scrc_top.sv ----
// Status/link-control and configuration registers behind the SPI port.
// Assumes mode 0 SPI pins already synchronous to clk and one register per frame.
`default_nettype none

module scrc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // SPI port
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_sdi,
    output logic spi_sdo_out,
    output logic spi_sdo_oe,
    // Converter events
    input wire logic [7:0] channel_ready_strobe,
    input wire logic channel_result_read,
    input wire logic config_checksum_error,
    input wire logic [7:0] write_lock_field,
    // Result ready pin
    output logic result_ready_pin_out,
    output logic result_ready_pin_oe,
    // Register contents
    output logic [7:0] channel_ready_flags,
    output logic [9:0] status_control,
    output logic [23:0] converter_config_zero,
    output logic config_interrupt_flag
);
    function automatic logic [23:0] read_value(input logic [4:0] addr,
            input logic [9:0] ctl, input logic [7:0] flags, input logic [23:0] cfg);
        if (addr == scrc_pkg::STATUS_ADDR) begin
            read_value = {ctl, 2'b00, 4'h0, flags};
        end else if (addr == scrc_pkg::CONFIG_ADDR) begin
            read_value = cfg;
        end else begin
            read_value = 24'h00_0000;
        end
    endfunction : read_value

    scrc_pkg::scrc_state_type state_reg, state_next;
    logic [4:0] count_reg, count_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [23:0] in_reg, in_next;
    logic [31:0] out_reg, out_next;
    logic sdo_reg, sdo_next;
    logic sdo_oe_reg, sdo_oe_next;
    logic sck_prev_reg;
    logic [9:0] ctl_reg, ctl_next;
    logic [23:0] cfg_reg, cfg_next;
    logic [7:0] flags_reg, flags_next;
    logic int_reg, int_next;
    logic pin_reg, pin_next;
    logic pin_oe_reg, pin_oe_next;
    logic status_clear;
    logic crc_clear, crc_shift, crc_bit;
    logic [15:0] crc_next, crc_value;
    logic sck_rise, sck_fall;
    logic [7:0] cmd_full;
    logic [23:0] data_full;
    logic key_match;

    assign sck_rise = spi_sck & ~sck_prev_reg;
    assign sck_fall = ~spi_sck & sck_prev_reg;
    assign cmd_full = {cmd_reg[6:0], spi_sdi};
    assign data_full = {in_reg[22:0], spi_sdi};
    assign key_match = (write_lock_field == scrc_pkg::UNLOCK_KEY_VALUE);

    scrc_checksum u_checksum (
        .clk(clk),
        .reset(reset),
        .clear(crc_clear),
        .shift(crc_shift),
        .bit_in(crc_bit),
        .crc_next(crc_next),
        .crc_value()
    );
    assign crc_value = crc_next;
    // Kept out of the framing process so the checksum feeds it without a loop
    assign crc_clear = spi_cs_n;
    assign crc_shift = !spi_cs_n && sck_rise &&
        (state_reg == scrc_pkg::SCRC_IDLE || state_reg == scrc_pkg::SCRC_DATA);
    // Read data is taken from what the device drives
    assign crc_bit = (state_reg == scrc_pkg::SCRC_DATA && cmd_reg[0]) ?
        sdo_reg : spi_sdi;

    // Link framing
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        cmd_next = cmd_reg;
        in_next = in_reg;
        out_next = out_reg;
        sdo_next = sdo_reg;
        sdo_oe_next = sdo_oe_reg;
        ctl_next = ctl_reg;
        cfg_next = cfg_reg;
        status_clear = 1'b0;
        if (spi_cs_n) begin
            state_next = scrc_pkg::SCRC_IDLE;
            count_next = 5'd0;
            out_next = 32'h0000_0000;
            sdo_oe_next = 1'b0;
        end else begin
            if (sck_fall) begin
                sdo_next = out_reg[31];
                out_next = {out_reg[30:0], 1'b0};
            end
            if (sck_rise) begin
                count_next = count_reg + 5'd1;
                case (state_reg)
                    scrc_pkg::SCRC_IDLE: begin
                        cmd_next = cmd_full;
                        if (count_reg == scrc_pkg::CMD_LAST) begin
                            count_next = 5'd0;
                            state_next = scrc_pkg::SCRC_DATA;
                            if (cmd_full[0]) begin
                                out_next = {read_value(cmd_full[5:1], ctl_reg,
                                    flags_reg, cfg_reg), 8'h00};
                                sdo_oe_next = 1'b1;
                            end
                        end
                    end
                    scrc_pkg::SCRC_DATA: begin
                        in_next = data_full;
                        if (count_reg == scrc_pkg::DATA_LAST) begin
                            count_next = 5'd0;
                            if (cmd_reg[0]) begin
                                status_clear = (cmd_reg[5:1] == scrc_pkg::STATUS_ADDR);
                            end else if (cmd_reg[5:1] == scrc_pkg::STATUS_ADDR) begin
                                ctl_next = data_full[23:14];
                            end else if (cmd_reg[5:1] == scrc_pkg::CONFIG_ADDR) begin
                                cfg_next = data_full & scrc_pkg::CONFIG_MASK;
                            end
                            if (ctl_reg[scrc_pkg::CTL_COMM_CHECKSUM]) begin
                                state_next = scrc_pkg::SCRC_CHECK;
                                out_next = {crc_value, 16'h0000};
                                sdo_oe_next = 1'b1;
                            end else begin
                                state_next = scrc_pkg::SCRC_DONE;
                                sdo_oe_next = 1'b0;
                            end
                        end
                    end
                    scrc_pkg::SCRC_CHECK: begin
                        if ((count_reg == scrc_pkg::CHECK_SHORT_LAST &&
                                !ctl_reg[scrc_pkg::CTL_WIDE_CHECKSUM]) ||
                                count_reg == scrc_pkg::CHECK_LONG_LAST) begin
                            state_next = scrc_pkg::SCRC_DONE;
                            sdo_oe_next = 1'b0;
                        end
                    end
                    scrc_pkg::SCRC_DONE: begin
                        count_next = count_reg;
                    end
                    default: begin
                        state_next = scrc_pkg::SCRC_IDLE;
                    end
                endcase
            end
        end
    end

    // Flags, interrupt and ready pin
    always_comb begin
        // Fresh results win over a clear in the same cycle
        flags_next = (status_clear ? 8'hFF : flags_reg) & ~channel_ready_strobe;
        int_next = (int_reg && !key_match) ||
            (config_checksum_error && ctl_reg[scrc_pkg::CTL_INT_ENABLE]);
        pin_next = !(int_next || (|channel_ready_strobe));
        pin_oe_next = !pin_next || ctl_reg[scrc_pkg::CTL_IDLE_DRIVE];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= scrc_pkg::SCRC_IDLE;
            count_reg <= 5'd0;
            cmd_reg <= 8'h00;
            in_reg <= 24'h00_0000;
            out_reg <= 32'h0000_0000;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
            ctl_reg <= scrc_pkg::STATUS_CTL_RESET;
            cfg_reg <= scrc_pkg::CONFIG_RESET;
            flags_reg <= 8'hFF;
            int_reg <= 1'b0;
            pin_reg <= 1'b1;
            pin_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            cmd_reg <= cmd_next;
            in_reg <= in_next;
            out_reg <= out_next;
            sdo_reg <= sdo_next;
            sdo_oe_reg <= sdo_oe_next;
            sck_prev_reg <= spi_sck;
            ctl_reg <= ctl_next;
            cfg_reg <= cfg_next;
            flags_reg <= flags_next;
            int_reg <= int_next;
            pin_reg <= pin_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign spi_sdo_out = sdo_reg;
    assign spi_sdo_oe = sdo_oe_reg;
    assign result_ready_pin_out = pin_reg;
    assign result_ready_pin_oe = pin_oe_reg;
    assign channel_ready_flags = flags_reg;
    assign status_control = ctl_reg;
    assign converter_config_zero = cfg_reg;
    assign config_interrupt_flag = int_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_data_end;
        state_reg == scrc_pkg::SCRC_DATA && !spi_cs_n && sck_rise &&
            count_reg == scrc_pkg::DATA_LAST;
    endsequence

    sequence s_status_read_end;
        s_data_end ##0 cmd_reg[0] ##0 cmd_reg[5:1] == scrc_pkg::STATUS_ADDR;
    endsequence

    AST_FLAGS_RESET_ON_READ: assert property (
        s_status_read_end |=> flags_reg == ~$past(channel_ready_strobe))
        else $error("ready flags not returned to one after status read");
    AST_READY_FLAG_SET: assert property (
        (|channel_ready_strobe) |=> (flags_reg & $past(channel_ready_strobe)) == 8'h00)
        else $error("ready flag not cleared on fresh result");
    AST_RESULT_READ_KEEPS: assert property (
        channel_result_read && !status_clear && channel_ready_strobe == 8'h00
            |=> $stable(flags_reg))
        else $error("result read changed ready flags");
    AST_INT_HOLDS_PIN: assert property (
        config_checksum_error && ctl_reg[scrc_pkg::CTL_INT_ENABLE] && !key_match
            ##1 !key_match |=> !pin_reg && pin_oe_reg)
        else $error("ready pin not held low by interrupt");
    AST_KEY_CLEARS: assert property (
        int_reg && key_match && !config_checksum_error |=> !int_reg)
        else $error("unlock key did not clear interrupt");
    AST_INT_DISABLED: assert property (
        !int_reg && !ctl_reg[scrc_pkg::CTL_INT_ENABLE] |=> !int_reg)
        else $error("interrupt raised while disabled");
    AST_IDLE_DRIVE: assert property (
        pin_reg |-> pin_oe_reg == $past(ctl_reg[scrc_pkg::CTL_IDLE_DRIVE]))
        else $error("ready pin idle drive wrong");
    AST_CHECKSUM_APPEND: assert property (
        s_data_end |=> state_reg == ($past(ctl_reg[scrc_pkg::CTL_COMM_CHECKSUM]) ?
            scrc_pkg::SCRC_CHECK : scrc_pkg::SCRC_DONE))
        else $error("checksum phase entry wrong");
    AST_CHECKSUM_WIDTH: assert property (
        state_reg == scrc_pkg::SCRC_CHECK && !spi_cs_n && sck_rise &&
            count_reg == scrc_pkg::CHECK_SHORT_LAST |=>
            (state_reg == scrc_pkg::SCRC_DONE) == !$past(ctl_reg[scrc_pkg::CTL_WIDE_CHECKSUM]))
        else $error("checksum length wrong");
    AST_CONFIG_UNIMPL: assert property (
        s_data_end ##0 !cmd_reg[0] ##0 cmd_reg[5:1] == scrc_pkg::CONFIG_ADDR
            |=> cfg_reg == ($past(data_full) & scrc_pkg::CONFIG_MASK))
        else $error("configuration write not masked");
    AST_UNIMPL_ZERO: assert property (
        state_reg == scrc_pkg::SCRC_IDLE && !spi_cs_n && sck_rise &&
            count_reg == scrc_pkg::CMD_LAST &&
            cmd_full[0] && cmd_full[5:1] == scrc_pkg::STATUS_ADDR
            |=> out_reg[21:14] == {2'b00, 4'h0, $past(flags_reg[7:6])})
        else $error("unimplemented status bits not zero");
endmodule : scrc_top

`default_nettype wire

// ---- test/scrc_host.sv ----
// Host model: drives mode 0 SPI frames toward the register block.
// Assumes the bench owns clk and calls xfer from one process at a time.
`default_nettype none

module scrc_host (
    // Clock
    input wire logic clk,
    // SPI pins
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_sdi,
    input wire logic spi_sdo_out,
    input wire logic spi_sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        spi_cs_n = 1'b1;
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [31:0] msg);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 31; i >= 0; i--) begin
            c = (c[15] ^ msg[i]) ? ((c << 1) ^ 16'h8005) : (c << 1);
        end
        return c;
    endfunction : crc16

    // Low phase of three clocks leaves room for the registered sdo update
    task automatic bit_io(input logic b, output logic r);
        // High phase of two clocks meets the minimum edge spacing
        repeat (2) @(posedge clk);
        #1;
        spi_sck = 1'b0;
        spi_sdi = b;
        repeat (3) @(posedge clk);
        #1;
        // Undriven sdo reads unknown, so a missing enable cannot pass
        r = spi_sdo_oe ? spi_sdo_out : 1'bx;
        spi_sck = 1'b1;
    endtask : bit_io

    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nchk,
                        output logic [23:0] rd, output logic [31:0] ck);
        logic [31:0] tx;
        logic r;
        tx = {cmd, wd};
        if (cmd[5:1] == 5'h0C) begin
            tx[13:12] = 2'b00;
        end
        rd = 24'h00_0000;
        ck = 32'h0000_0000;
        @(posedge clk);
        #1;
        spi_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            bit_io(tx[i], r);
            if (i < 24) begin
                rd[i] = r;
            end
        end
        for (int i = nchk - 1; i >= 0; i--) begin
            bit_io(1'b0, r);
            ck[i] = r;
        end
        repeat (2) @(posedge clk);
        #1;
        spi_sck = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        repeat (2) @(posedge clk);
    endtask : xfer
endmodule : scrc_host

`default_nettype wire

// ---- test/status_crc_ready_control_bench.sv ----
// Self-checking bench: register frames through the host model plus event pulses.
// Assumes scrc_top and scrc_host are compiled first.
`default_nettype none

`define CHK(nm, e, g) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
end

module status_crc_ready_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic spi_cs_n, spi_sck, spi_sdi, spi_sdo_out, spi_sdo_oe;
    logic [7:0] channel_ready_strobe = 8'h00;
    logic channel_result_read = 1'b0;
    logic config_checksum_error = 1'b0;
    logic [7:0] write_lock_field = 8'h00;
    logic result_ready_pin_out, result_ready_pin_oe, config_interrupt_flag;
    logic [7:0] channel_ready_flags;
    logic [9:0] status_control;
    logic [23:0] converter_config_zero, rd;
    logic [31:0] ck;
    logic [2:0] int_pin;
    int fail_count = 0;
    int n_compared = 0;

    always #20 clk = ~clk;

    assign int_pin = {config_interrupt_flag, result_ready_pin_out, result_ready_pin_oe};

    scrc_top uut (
        .clk(clk), .reset(reset),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
        .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe),
        .channel_ready_strobe(channel_ready_strobe), .channel_result_read(channel_result_read),
        .config_checksum_error(config_checksum_error), .write_lock_field(write_lock_field),
        .result_ready_pin_out(result_ready_pin_out), .result_ready_pin_oe(result_ready_pin_oe),
        .channel_ready_flags(channel_ready_flags), .status_control(status_control),
        .converter_config_zero(converter_config_zero), .config_interrupt_flag(config_interrupt_flag)
    );

    scrc_host host (
        .clk(clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_sdi(spi_sdi),
        .spi_sdo_out(spi_sdo_out), .spi_sdo_oe(spi_sdo_oe)
    );

    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    function automatic logic [23:0] stat(input logic [9:0] c, input logic [7:0] f);
        return {c, 6'b00_0000, f};
    endfunction : stat

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        `CHK("flags", 8'hFF, channel_ready_flags);
        `CHK("config", 24'h38_6050, converter_config_zero);
        `CHK("status_ctl", 10'h2A4, status_control);
        `CHK("pin_oe", 1'b0, result_ready_pin_oe);
        host.xfer(8'h1B, 24'h00_0000, 0, rd, ck);
        `CHK("cfg_read", 24'h38_6050, rd);
        host.xfer(8'h1A, 24'hFF_FFFF, 0, rd, ck);
        host.xfer(8'h1B, 24'h00_0000, 0, rd, ck);
        `CHK("cfg_mask", 24'hFF_E0FF, rd);
        host.xfer(8'h0B, 24'h00_0000, 0, rd, ck);
        `CHK("unmapped", 24'h00_0000, rd);
        tick();
        channel_ready_strobe = 8'h09;
        tick();
        channel_ready_strobe = 8'h00;
        `CHK("flags_set", 8'hF6, channel_ready_flags);
        `CHK("pin_pulse", 2'b01, {result_ready_pin_out, result_ready_pin_oe});
        channel_result_read = 1'b1;
        tick();
        channel_result_read = 1'b0;
        tick();
        `CHK("flags_kept", 8'hF6, channel_ready_flags);
        host.xfer(8'h19, 24'h00_0000, 0, rd, ck);
        `CHK("status_read", stat(10'h2A4, 8'hF6), rd);
        `CHK("flags_clear", 8'hFF, channel_ready_flags);
        config_checksum_error = 1'b1;
        tick();
        config_checksum_error = 1'b0;
        tick();
        `CHK("int_off", 3'b010, int_pin);
        host.xfer(8'h18, 24'hB9_4000, 0, rd, ck);
        `CHK("status_ctl_wr", 10'h2E5, status_control);
        config_checksum_error = 1'b1;
        tick();
        config_checksum_error = 1'b0;
        // Pin must stay low for as long as the key is absent
        for (int i = 0; i < 6; i++) begin
            tick();
            `CHK("int_hold", 3'b101, int_pin);
        end
        write_lock_field = 8'hA5;
        tick();
        tick();
        `CHK("int_clear", 3'b011, int_pin);
        write_lock_field = 8'h00;
        host.xfer(8'h18, 24'hB9_C000, 0, rd, ck);
        host.xfer(8'h1B, 24'h00_0000, 16, rd, ck);
        `CHK("crc_data", 24'hFF_E0FF, rd);
        `CHK("crc16", {16'h0000, host.crc16({8'h1B, 24'hFF_E0FF})}, ck);
        // Width change frame: checksum length of this frame is left unchecked
        host.xfer(8'h18, 24'hBD_C000, 32, rd, ck);
        host.xfer(8'h19, 24'h00_0000, 32, rd, ck);
        `CHK("status_wide", stat(10'h2F7, 8'hFF), rd);
        `CHK("crc32", {host.crc16({8'h19, stat(10'h2F7, 8'hFF)}), 16'h0000}, ck);
        test_done();
    end
endmodule : status_crc_ready_control_bench

`default_nettype wire
